// [rtl/siams_pkg.sv]
// Constants and types for the synchronous DRAM command, burst and mode logic
package siams_pkg;
  localparam int ROW_W = 13;
  localparam int BANK_W = 2;
  localparam int NBANK = 4;
  localparam int ADDR_W = 12;
  localparam int COL_MAX_W = 11;
  localparam int DQ_W_DEF = 16;
  localparam int COL_W_DEF = 9;
  localparam int PRE_ALL_BIT = 10;
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h000;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_2 = 3'h2;
  localparam logic [2:0] CL_3 = 3'h3;
  // Command codes as {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_STOP = 3'h6;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_NOP = 3'h7;

  typedef struct packed {
    logic [1:0] reserved;
    logic write_burst_bit;
    logic op_mode_bit_hi;
    logic op_mode_bit_lo;
    logic [2:0] read_latency;
    logic burst_type_bit;
    logic [2:0] burst_len;
  } siams_mode_t;

  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_MAX_W-1:0] col;
  } siams_loc_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } siams_burst_t;
endpackage

// [rtl/siams_core.sv]
// Synchronous DRAM device core: command decode, open rows, mode register and bursts
// Operation
// - All commands and addresses are sampled on the rising clock edge only.
// - Four banks of 8192 rows; column count follows the data width variant.
// - Row-open command takes bank from bank selects, row from thirteen address lines.
// - Read or write takes the burst start column from the address lines.
// - Mode register is undefined until loaded; loaded value is kept until reloaded.
// - Data outputs are high-impedance once the mode load command is issued.
// - Mode bits: length 0-2, type 3, latency 4-6, op mode 7-8, write burst 9.
// - Lengths 1, 2, 4, 8 for both types; full row only sequential.
// - A burst stop command ends a running burst, giving arbitrary lengths.
// - Upper column bits pick an aligned block; bursts wrap inside the block.
// - A full-row burst wraps from the row end back to its start.
// - Both operating mode bits zero give normal operation; others not programmed.
// - Write burst bit set makes every write a single-location access.
// - Burst type bit selects sequential or interleaved column order.
// - Read latency of two or three clocks to the first output data.
// - Address lines 0 to 11 carry the mode value during mode load.
`timescale 1ns/1ps
module siams_core
  import siams_pkg::*;
#(
  parameter int DQ_W = siams_pkg::DQ_W_DEF,
  parameter int COL_W = siams_pkg::COL_W_DEF
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic bank_select_lo_i,
  input wire logic bank_select_hi_i,
  input wire logic [siams_pkg::ADDR_W-1:0] addr_i,
  input wire logic top_address_line_i,
  input wire logic dqm_i,
  input wire logic [DQ_W-1:0] dq_i,
  output logic [DQ_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic arr_rd_o,
  output siams_pkg::siams_loc_t arr_loc_o,
  input wire logic [DQ_W-1:0] arr_rdata_i,
  output logic arr_wr_valid_o,
  output siams_pkg::siams_loc_t arr_wr_loc_o,
  output logic [DQ_W-1:0] arr_wr_data_o,
  input wire logic arr_wr_ready_i,
  output logic wbuf_ready_o,
  output siams_pkg::siams_mode_t mode_o,
  output logic mode_valid_o,
  output logic banks_idle_o
);
  import siams_pkg::*;

  // ****************************************
  // Command decode
  // ****************************************
  wire [2:0] cmd = {ras_n_i, cas_n_i, we_n_i};
  wire cmd_ok = cke_i && !cs_n_i;
  wire [BANK_W-1:0] bank_in = {bank_select_hi_i, bank_select_lo_i};
  wire [ROW_W-1:0] row_in = {top_address_line_i, addr_i};
  wire [COL_MAX_W:0] col_full = {1'b0, addr_i[11], addr_i[9:0]};
  wire [COL_W-1:0] col_in = col_full[COL_W-1:0];
  wire burst_cmd = cmd_ok && cmd != CMD_NOP;

  siams_mode_t mode_r;
  logic mode_valid_r;
  logic [NBANK-1:0] act_r;
  logic [ROW_W-1:0] row_r [NBANK];
  wire all_idle = ~|act_r;
  wire act_go = cmd_ok && cmd == CMD_ACT && !act_r[bank_in];
  wire pre_go = cmd_ok && cmd == CMD_PRE;
  wire mode_ok = mode_valid_r && !mode_r.op_mode_bit_hi && !mode_r.op_mode_bit_lo;
  wire rd_go = cmd_ok && cmd == CMD_RD && act_r[bank_in] && mode_ok;
  wire wr_go = cmd_ok && cmd == CMD_WR && act_r[bank_in] && mode_ok;
  wire stop_go = cmd_ok && cmd == CMD_STOP;
  wire lmr_go = cmd_ok && cmd == CMD_LMR && all_idle;

  // ****************************************
  // Open rows per bank
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NBANK; g++)
    begin : g_bank
      wire hit = bank_in == BANK_W'(g);
      always_ff @(posedge core_clk_i)
      begin
        if (rst_i)
        begin
          act_r[g] <= 1'b0;
          row_r[g] <= '0;
        end
        else if (act_go && hit)
        begin
          act_r[g] <= 1'b1;
          row_r[g] <= row_in;
        end
        else if (pre_go && (addr_i[PRE_ALL_BIT] || hit))
          act_r[g] <= 1'b0;
      end
    end
  endgenerate

  // ****************************************
  // Mode register
  // ****************************************
  // No reset pin on a real part; the reset here only gives simulation a known start
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      mode_r <= siams_mode_t'(MODE_RST);
      mode_valid_r <= 1'b0;
    end
    else if (lmr_go)
    begin
      mode_r <= siams_mode_t'(addr_i);
      mode_valid_r <= 1'b1;
    end
  end

  // ****************************************
  // Burst sequencer
  // ****************************************
  // Reserved length codes fall back to single beats; interleaved full row runs sequential
  wire [COL_W-1:0] len_mask =
    (mode_r.burst_len == BL_2) ? COL_W'(1) :
    (mode_r.burst_len == BL_4) ? COL_W'(3) :
    (mode_r.burst_len == BL_8) ? COL_W'(7) :
    (mode_r.burst_len == BL_FULL) ? '1 : '0;
  wire len_full = mode_r.burst_len == BL_FULL;

  siams_burst_t state_r, state_nxt;
  logic [BANK_W-1:0] bank_r, bank_nxt;
  logic [COL_W-1:0] start_r, start_nxt, cnt_r, cnt_nxt, mask_r, mask_nxt;
  logic ilv_r, ilv_nxt, full_r, full_nxt;

  always_comb
  begin
    state_nxt = state_r;
    bank_nxt = bank_r;
    start_nxt = start_r;
    cnt_nxt = cnt_r + COL_W'(1);
    mask_nxt = mask_r;
    ilv_nxt = ilv_r;
    full_nxt = full_r;
    unique case (state_r)
      ST_IDLE: cnt_nxt = cnt_r;
      ST_READ, ST_WRITE:
        if (cnt_r == mask_r && !full_r)
          state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
    if (rd_go || wr_go)
    begin
      state_nxt = rd_go ? ST_READ : ST_WRITE;
      bank_nxt = bank_in;
      start_nxt = col_in;
      cnt_nxt = '0;
      mask_nxt = (wr_go && mode_r.write_burst_bit) ? '0 : len_mask;
      full_nxt = len_full && !(wr_go && mode_r.write_burst_bit);
      ilv_nxt = mode_r.burst_type_bit && !len_full;
    end
    else if (stop_go || lmr_go || (pre_go && (addr_i[PRE_ALL_BIT] || bank_in == bank_r)))
      state_nxt = ST_IDLE;
  end

  wire [COL_W-1:0] blk_base = start_nxt & ~mask_nxt;
  wire [COL_W-1:0] seq_off = start_nxt + cnt_nxt;
  wire [COL_W-1:0] ilv_off = start_nxt ^ cnt_nxt;
  wire [COL_W-1:0] beat_col = blk_base | ((ilv_nxt ? ilv_off : seq_off) & mask_nxt);
  wire siams_loc_t beat_loc = {bank_nxt, row_r[bank_nxt], COL_MAX_W'(beat_col)};

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      bank_r <= '0;
      start_r <= '0;
      cnt_r <= '0;
      mask_r <= '0;
      ilv_r <= 1'b0;
      full_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      bank_r <= bank_nxt;
      start_r <= start_nxt;
      cnt_r <= cnt_nxt;
      mask_r <= mask_nxt;
      ilv_r <= ilv_nxt;
      full_r <= full_nxt;
    end
  end

  // ****************************************
  // Read path and output latency
  // ****************************************
  wire cl3 = mode_r.read_latency == CL_3;
  logic dqm_d_r, pipe_v_r, arr_rd_r, dq_oe_r;
  logic [DQ_W-1:0] pipe_d_r, dq_r;
  siams_loc_t arr_loc_r;
  wire rd_live = arr_rd_r && !dqm_d_r;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      dqm_d_r <= 1'b1;
      arr_rd_r <= 1'b0;
      arr_loc_r <= '0;
      pipe_v_r <= 1'b0;
      pipe_d_r <= '0;
      dq_oe_r <= 1'b0;
      dq_r <= '0;
    end
    else
    begin
      dqm_d_r <= dqm_i;
      arr_rd_r <= state_nxt == ST_READ;
      arr_loc_r <= beat_loc;
      pipe_v_r <= rd_live && !lmr_go;
      pipe_d_r <= arr_rdata_i;
      dq_oe_r <= !lmr_go && (cl3 ? pipe_v_r : rd_live);
      dq_r <= cl3 ? pipe_d_r : arr_rdata_i;
    end
  end

  // ****************************************
  // Two-entry write buffer
  // ****************************************
  // The pins cannot stall, so a full buffer drops the beat; wbuf_ready_o warns ahead
  siams_loc_t wloc_r [2];
  logic [DQ_W-1:0] wdat_r [2];
  logic [1:0] wv_r;
  logic wbuf_ready_r;
  wire pop = wv_r[0] && arr_wr_ready_i;
  wire v0_left = pop ? wv_r[1] : wv_r[0];
  wire v1_left = pop ? 1'b0 : wv_r[1];
  wire push = state_nxt == ST_WRITE && !dqm_i && !v1_left;
  wire v1_nxt = v1_left || (push && v0_left);

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      wv_r <= 2'b00;
      wbuf_ready_r <= 1'b1;
      wloc_r[0] <= '0;
      wloc_r[1] <= '0;
      wdat_r[0] <= '0;
      wdat_r[1] <= '0;
    end
    else
    begin
      wv_r <= {v1_nxt, v0_left || push};
      wbuf_ready_r <= !v1_nxt;
      if (push && !v0_left)
      begin
        wloc_r[0] <= beat_loc;
        wdat_r[0] <= dq_i;
      end
      else if (pop)
      begin
        wloc_r[0] <= wloc_r[1];
        wdat_r[0] <= wdat_r[1];
      end
      if (push && v0_left)
      begin
        wloc_r[1] <= beat_loc;
        wdat_r[1] <= dq_i;
      end
    end
  end

  logic idle_r;
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      idle_r <= 1'b1;
    else
      idle_r <= all_idle;
  end

  assign dq_o = dq_r;
  assign dq_oe_o = dq_oe_r;
  assign arr_rd_o = arr_rd_r;
  assign arr_loc_o = arr_loc_r;
  assign arr_wr_valid_o = wv_r[0];
  assign arr_wr_loc_o = wloc_r[0];
  assign arr_wr_data_o = wdat_r[0];
  assign wbuf_ready_o = wbuf_ready_r;
  assign mode_o = mode_r;
  assign mode_valid_o = mode_valid_r;
  assign banks_idle_o = idle_r;

  // ****************************************
  // Checks
  // ****************************************
  chk_mode_load: assert property (@(posedge core_clk_i) disable iff (rst_i)
    lmr_go |=> (mode_r == $past(addr_i) && mode_valid_r)) else $error("mode load value wrong");
  chk_lmr_hiz: assert property (@(posedge core_clk_i) disable iff (rst_i)
    lmr_go |=> !dq_oe_o [*2]) else $error("outputs driven after mode load");
  chk_lat_two: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rd_go && !dqm_i && !cl3) ##1 !lmr_go |-> ##1 dq_oe_o) else $error("latency two missed");
  chk_lat_three: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rd_go && !dqm_i && cl3) ##1 !lmr_go |-> !dq_oe_o ##1 (!lmr_go ##1 dq_oe_o))
    else $error("latency three missed");
  chk_len_four: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rd_go && mode_r.burst_len == BL_4) ##1 !burst_cmd [*4] |-> arr_rd_o ##1 !arr_rd_o)
    else $error("burst of four has wrong length");
  chk_block_wrap: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rd_go && mode_r.burst_len == BL_4 && !mode_r.burst_type_bit && col_in[1:0] == 2'h3)
    ##1 !burst_cmd |=> (arr_loc_o.col[1:0] == 2'h0 && arr_loc_o.col[COL_W-1:2] == $past(col_in[COL_W-1:2], 2)))
    else $error("sequential burst left its block");
  chk_ilv_order: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rd_go && mode_r.burst_len == BL_8 && mode_r.burst_type_bit && col_in[2:0] == 3'h5)
    ##1 !burst_cmd |=> arr_loc_o.col[2:0] == 3'h4) else $error("interleaved order wrong");
  chk_wr_single: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (wr_go && mode_r.write_burst_bit) ##1 !burst_cmd |=> state_r == ST_IDLE)
    else $error("write burst not single");
  chk_burst_stop: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (stop_go && !rd_go && !wr_go) |=> (state_r == ST_IDLE && !arr_rd_o)) else $error("burst not stopped");
  chk_row_open: assert property (@(posedge core_clk_i) disable iff (rst_i)
    act_go |=> (act_r[$past(bank_in)] && row_r[$past(bank_in)] == $past(row_in)))
    else $error("row not opened");
endmodule

// [verification/siams_array_model.sv]
// Behavioural array behind the device core: location-derived read words and a stallable, logging write port
`timescale 1ns/1ps
module siams_array_model
  import siams_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire siams_pkg::siams_loc_t rd_loc_i,
  output logic [15:0] rdata_o,
  input wire logic wr_valid_i,
  input wire siams_pkg::siams_loc_t wr_loc_i,
  input wire logic [15:0] wr_data_i,
  output logic wr_ready_o,
  input wire logic stall_i,
  output logic [7:0] pops_o,
  output logic [15:0] last_data_o,
  output siams_pkg::siams_loc_t last_loc_o
);
  // Word tied to its location so a wrong column is visible
  assign rdata_o = {rd_loc_i.col[7:0], rd_loc_i.row[5:0], rd_loc_i.bank};
  assign wr_ready_o = !stall_i;
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pops_o <= 8'h00;
    end
    else if (wr_valid_i && wr_ready_o)
    begin
      pops_o <= pops_o + 8'h01;
      last_data_o <= wr_data_i;
      last_loc_o <= wr_loc_i;
    end
  end
endmodule

// [verification/test_sdram_init_and_mode_setup.sv]
// Testbench driving the command pins and checking bursts, mode loads and writes
`timescale 1ns/1ps
module test_sdram_init_and_mode_setup;
  import siams_pkg::*;
  localparam logic [12:0] ROW = 13'h1abc;
  // Power-up wait of 100 us in 25 ns cycles, an exact count
  localparam int INIT_WAIT = 4000;
  logic core_clk_i, rst_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i;
  logic bank_select_lo_i, bank_select_hi_i, top_address_line_i, dqm_i, stall;
  logic [11:0] addr_i;
  logic [15:0] dq_i, dq_o, rdata, wdata, last_data;
  logic dq_oe_o, arr_rd_o, arr_wr_valid_o, wr_ready, wbuf_ready_o, mode_valid_o, banks_idle_o;
  siams_loc_t arr_loc_o, arr_wr_loc_o, last_loc;
  siams_mode_t mode_o;
  logic [7:0] pops;
  int errors, n_compared;

  siams_core siams_core_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
    .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .bank_select_lo_i(bank_select_lo_i),
    .bank_select_hi_i(bank_select_hi_i), .addr_i(addr_i), .top_address_line_i(top_address_line_i),
    .dqm_i(dqm_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .arr_rd_o(arr_rd_o),
    .arr_loc_o(arr_loc_o), .arr_rdata_i(rdata), .arr_wr_valid_o(arr_wr_valid_o),
    .arr_wr_loc_o(arr_wr_loc_o), .arr_wr_data_o(wdata), .arr_wr_ready_i(wr_ready),
    .wbuf_ready_o(wbuf_ready_o), .mode_o(mode_o), .mode_valid_o(mode_valid_o), .banks_idle_o(banks_idle_o));

  siams_array_model siams_array_model_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .rd_loc_i(arr_loc_o),
    .rdata_o(rdata), .wr_valid_i(arr_wr_valid_o), .wr_loc_i(arr_wr_loc_o), .wr_data_i(wdata),
    .wr_ready_o(wr_ready), .stall_i(stall), .pops_o(pops), .last_data_o(last_data), .last_loc_o(last_loc));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic stop_test();
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic nop(input int n);
    repeat (n)
    begin
      @(posedge core_clk_i);
      #2;
    end
  endtask

  // Command held over one edge, then inhibit
  task automatic cmd(input logic [2:0] c, input logic [1:0] bk, input logic [12:0] a);
    cs_n_i = 1'b0;
    {ras_n_i, cas_n_i, we_n_i} = c;
    {bank_select_hi_i, bank_select_lo_i} = bk;
    addr_i = a[11:0];
    top_address_line_i = a[12];
    @(posedge core_clk_i);
    #2;
    cs_n_i = 1'b1;
  endtask

  function automatic logic [10:0] col_at(input logic [10:0] c0, input int i, input int n, input bit il);
    logic [10:0] m;
    m = n[10:0] - 11'h001;
    col_at = il ? ((c0 & ~m) | ((c0 ^ i[10:0]) & m)) : ((c0 & ~m) | ((c0 + i[10:0]) & m));
  endfunction

  // Mode values loaded with bank selects and top line low
  task automatic mode_set(input logic [11:0] m);
    cmd(CMD_PRE, 2'h0, 13'h0400);
    nop(2);
    chk(banks_idle_o, 1'b1);
    cmd(CMD_LMR, 2'h0, {1'b0, m});
    chk(mode_o, m);
    chk(mode_valid_o, 1'b1);
    chk(dq_oe_o, 1'b0);
    nop(2);
    cmd(CMD_ACT, 2'h2, ROW);
    nop(2);
    chk(banks_idle_o, 1'b0);
  endtask

  // Full-row bursts wrap over the whole row of the default width
  task automatic rd(input logic [11:0] m, input logic [10:0] c0, input int n, input bit il, input bit full);
    int cl, j, nb;
    logic [10:0] c;
    cl = (m[6:4] == CL_3) ? 3 : 2;
    nb = full ? (1 << COL_W_DEF) : n;
    mode_set(m);
    cmd(CMD_RD, 2'h2, {2'b00, c0});
    for (int k = 1; k < n + cl; k++)
    begin
      j = k - cl;
      c = col_at(c0, k - 1, nb, il);
      if (k <= n)
      begin
        chk(arr_rd_o, 1'b1);
        chk(arr_loc_o, {2'h2, ROW, c});
      end
      else if (!full)
        chk(arr_rd_o, 1'b0);
      c = col_at(c0, j, nb, il);
      if (j >= 0 && j < n)
      begin
        chk(dq_oe_o, 1'b1);
        chk(dq_o, {c[7:0], ROW[5:0], 2'h2});
      end
      else if (!full)
        chk(dq_oe_o, 1'b0);
      nop(1);
    end
    if (full)
    begin
      cmd(CMD_STOP, 2'h2, 13'h0000);
      chk(arr_rd_o, 1'b0);
    end
    nop(3);
  endtask

  // ****************************************
  // Stimulus
  // ****************************************
  initial
  begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  initial
  begin
    repeat (INIT_WAIT + 2000) @(posedge core_clk_i);
    errors++;
    stop_test();
  end

  initial
  begin
    errors = 0;
    n_compared = 0;
    {rst_i, cs_n_i, ras_n_i, cas_n_i, we_n_i} = 5'h1f;
    {cke_i, bank_select_lo_i, bank_select_hi_i, top_address_line_i, dqm_i, stall} = 6'h00;
    addr_i = 12'h000;
    dq_i = 16'h0000;
    repeat (5) @(posedge core_clk_i);
    #2;
    rst_i = 1'b0;
    chk({mode_valid_o, mode_o}, 13'h0000);
    chk({dq_oe_o, banks_idle_o, wbuf_ready_o}, 3'h3);
    // Clock gate rises halfway through the power-up wait
    nop(INIT_WAIT / 2);
    cke_i = 1'b1;
    nop(INIT_WAIT - INIT_WAIT / 2);
    cmd(CMD_PRE, 2'h0, 13'h0400);
    nop(2);
    repeat (2)
    begin
      cmd(3'h1, 2'h0, 13'h0000);
      nop(2);
    end
    // Reads refused before any mode load; mode load refused with a row open
    cmd(CMD_ACT, 2'h2, ROW);
    nop(1);
    cmd(CMD_RD, 2'h2, 13'h0000);
    chk(arr_rd_o, 1'b0);
    nop(1);
    cmd(CMD_LMR, 2'h0, 13'h0022);
    chk(mode_valid_o, 1'b0);
    nop(1);
    // A test operating mode refuses reads; a refresh may follow the mode load
    cmd(CMD_PRE, 2'h0, 13'h0400);
    nop(2);
    cmd(CMD_LMR, 2'h0, 13'h00a2);
    nop(2);
    cmd(3'h1, 2'h0, 13'h0000);
    nop(2);
    cmd(CMD_ACT, 2'h2, ROW);
    nop(1);
    cmd(CMD_RD, 2'h2, 13'h0000);
    chk(arr_rd_o, 1'b0);
    chk(mode_o, 12'h0a2);
    nop(1);
    rd(12'h022, 11'h001, 4, 1'b0, 1'b0);
    rd(12'h02a, 11'h001, 4, 1'b1, 1'b0);
    rd(12'h03b, 11'h005, 8, 1'b1, 1'b0);
    rd(12'h033, 11'h00e, 8, 1'b0, 1'b0);
    rd(12'h020, 11'h005, 1, 1'b0, 1'b0);
    rd(12'h027, 11'h1fe, 4, 1'b0, 1'b1);
    // Far side stalls while a two-beat write fills the buffer
    mode_set(12'h021);
    stall = 1'b1;
    dq_i = 16'h1234;
    cmd(CMD_WR, 2'h2, 13'h0005);
    dq_i = 16'h5678;
    nop(3);
    chk({wbuf_ready_o, arr_wr_valid_o}, 2'h1);
    stall = 1'b0;
    nop(3);
    chk({pops, last_data}, {8'h02, 16'h5678});
    chk(last_loc, {2'h2, ROW, 11'h004});
    chk(arr_wr_valid_o, 1'b0);
    mode_set(12'h222);
    dq_i = 16'h9abc;
    cmd(CMD_WR, 2'h2, 13'h0007);
    dq_i = 16'h0f0f;
    nop(4);
    chk({pops, last_data}, {8'h03, 16'h9abc});
    // A masked write beat never reaches the buffer
    dqm_i = 1'b1;
    cmd(CMD_WR, 2'h2, 13'h0009);
    dqm_i = 1'b0;
    nop(2);
    chk({pops, arr_wr_valid_o}, {8'h03, 1'b0});
    // Precharge of a closed bank leaves the open one alone
    cmd(CMD_PRE, 2'h1, 13'h0000);
    nop(2);
    chk(banks_idle_o, 1'b0);
    cmd(CMD_PRE, 2'h2, 13'h0000);
    nop(2);
    chk(banks_idle_o, 1'b1);
    stop_test();
  end
endmodule
